// >>> core/swire_master.sv
// Added by the designer: the AXI4-Lite slave port and the address map.
`include "swire_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module swire_master (
  input wire logic I_CLK, // main clock, 250 MHz
  input wire logic I_RST_N, // async reset, active low
  input wire logic [3:0] I_AWADDR, // write address
  input wire logic I_AWVALID, // write address valid
  output logic O_AWREADY, // write address ready
  input wire logic [31:0] I_WDATA, // write data
  input wire logic [3:0] I_WSTRB, // write strobes
  input wire logic I_WVALID, // write data valid
  output logic O_WREADY, // write data ready
  output logic [1:0] O_BRESP, // write response
  output logic O_BVALID, // write response valid
  input wire logic I_BREADY, // write response ready
  input wire logic [3:0] I_ARADDR, // read address
  input wire logic I_ARVALID, // read address valid
  output logic O_ARREADY, // read address ready
  output logic [31:0] O_RDATA, // read data
  output logic [1:0] O_RRESP, // read response
  output logic O_RVALID, // read data valid
  input wire logic I_RREADY, // read data ready
  input wire logic I_WIRE, // wire level in
  output logic O_WIRE, // wire drive value, always low
  output logic O_WIRE_OE, // high while pulling the wire low
  output logic O_IRQ // level interrupt
);
  swire_pkg::state_t r;
  swire_pkg::state_t next_r;
  logic wire_in;
  logic aw_now;
  logic w_now;
  logic [3:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [2:0] ev;
  logic [2:0] clr;

  // a change counts once it reaches the third stage, both arms giving r.sync[2]
  assign wire_in = (r.sync[2] == r.sync[1]) ? r.sync[1] : r.sync[2];

  always_comb
  begin
    next_r = r;
    ev = 3'h0;
    clr = 3'h0;
    aw_now = 1'b0;
    w_now = 1'b0;
    wa = r.bus.awaddr;
    wd = r.bus.wdata;
    ws = r.bus.wstrb;
    next_r.sync = {r.sync[1:0], I_WIRE};
    // timebase: one tick per microsecond
    next_r.tick = 1'b0;
    if (r.tb_cnt == `SW_TB_DIV - 9'd1)
    begin
      next_r.tb_cnt = 9'h0;
      next_r.tick = 1'b1;
    end
    else
    begin
      next_r.tb_cnt = r.tb_cnt + 9'd1;
    end
    // write channel
    if (I_AWVALID && r.bus.awready)
    begin
      aw_now = 1'b1;
      next_r.bus.awready = 1'b0;
      next_r.bus.aw_got = 1'b1;
      next_r.bus.awaddr = I_AWADDR;
      wa = I_AWADDR;
    end
    if (I_WVALID && r.bus.wready)
    begin
      w_now = 1'b1;
      next_r.bus.wready = 1'b0;
      next_r.bus.w_got = 1'b1;
      next_r.bus.wdata = I_WDATA;
      next_r.bus.wstrb = I_WSTRB;
      wd = I_WDATA;
      ws = I_WSTRB;
    end
    if ((r.bus.aw_got || aw_now) && (r.bus.w_got || w_now) && !r.bus.bvalid)
    begin
      next_r.bus.aw_got = 1'b0;
      next_r.bus.w_got = 1'b0;
      next_r.bus.bvalid = 1'b1;
      next_r.bus.bresp = 2'h0;
      if (wa[3:2] == `SW_CTRL_OFS >> 2)
      begin
        if (ws[0] && r.state == swire_pkg::ST_IDLE)
        begin
          next_r.ctrl.reset_presence_request = wd[`SW_RPP_BIT];
          next_r.ctrl.write_zero_request = wd[`SW_WZ_BIT];
          next_r.ctrl.write_one_or_read_request = wd[`SW_WOR_BIT];
        end
      end
      else if (wa[3:2] == `SW_IRQ_OFS >> 2)
      begin
        if (ws[0])
          clr = wd[2:0];
      end
      else if (wa[3:2] == `SW_MASK_OFS >> 2)
      begin
        if (ws[0])
          next_r.irq_mask = wd[2:0];
      end
      else if (wa[3:2] != `SW_STAT_OFS >> 2)
        next_r.bus.bresp = 2'h2;
    end
    if (r.bus.bvalid && I_BREADY)
    begin
      next_r.bus.bvalid = 1'b0;
      next_r.bus.awready = 1'b1;
      next_r.bus.wready = 1'b1;
    end
    // read channel
    if (I_ARVALID && r.bus.arready)
    begin
      next_r.bus.arready = 1'b0;
      next_r.bus.rvalid = 1'b1;
      next_r.bus.rresp = 2'h0;
      next_r.bus.rdata = 32'h0;
      if (I_ARADDR[3:2] == `SW_CTRL_OFS >> 2)
        next_r.bus.rdata[2:0] = {r.ctrl.write_one_or_read_request,
          r.ctrl.write_zero_request, r.ctrl.reset_presence_request};
      else if (I_ARADDR[3:2] == `SW_STAT_OFS >> 2)
        next_r.bus.rdata[2:0] = {r.state != swire_pkg::ST_IDLE,
          r.read_bit_value, r.presence_status};
      else if (I_ARADDR[3:2] == `SW_IRQ_OFS >> 2)
        next_r.bus.rdata[2:0] = r.irq_stat;
      else
        next_r.bus.rdata[2:0] = r.irq_mask;
    end
    if (r.bus.rvalid && I_RREADY)
    begin
      next_r.bus.rvalid = 1'b0;
      next_r.bus.arready = 1'b1;
    end
    // wire sequencer, leaves ST_IDLE on a request at once, otherwise advances on the microsecond tick
    if (r.tick)
      next_r.us_cnt = r.us_cnt + 10'd1;
    case (r.state)
      swire_pkg::ST_IDLE:
      begin
        next_r.us_cnt = 10'h0;
        if (r.ctrl.reset_presence_request)
        begin
          next_r.state = swire_pkg::ST_RST_LOW;
          next_r.wire_low = 1'b1;
          next_r.presence_seen = 1'b0;
        end
        else if (r.ctrl.write_zero_request)
        begin
          next_r.state = swire_pkg::ST_WZ_LOW;
          next_r.wire_low = 1'b1;
        end
        else if (r.ctrl.write_one_or_read_request)
        begin
          next_r.state = swire_pkg::ST_WOR_LOW;
          next_r.wire_low = 1'b1;
        end
      end
      swire_pkg::ST_RST_LOW:
        if (r.tick && r.us_cnt == `SW_RST_LOW_US - 10'd1)
        begin
          next_r.state = swire_pkg::ST_RST_REC;
          next_r.wire_low = 1'b0;
          next_r.us_cnt = 10'h0;
        end
      swire_pkg::ST_RST_REC:
      begin
        // the slave answers within 15-60 us, lasting 60-240 us
        if (r.tick && r.us_cnt == `SW_PRES_SAMPLE_US)
        begin
          next_r.presence_status = !wire_in;
          next_r.ctrl.reset_presence_request = 1'b0;
        end
        if (r.tick && r.us_cnt == `SW_RST_REC_US - 10'd1)
        begin
          next_r.state = swire_pkg::ST_IDLE;
          ev[`SW_EV_RST] = 1'b1;
        end
      end
      swire_pkg::ST_WZ_LOW:
        if (r.tick && r.us_cnt == `SW_WZ_LOW_US - 10'd1)
        begin
          next_r.state = swire_pkg::ST_SLOT_REST;
          next_r.wire_low = 1'b0;
        end
      swire_pkg::ST_SLOT_REST:
        if (r.tick && r.us_cnt == `SW_SLOT_US - 10'd1)
        begin
          next_r.state = swire_pkg::ST_IDLE;
          next_r.ctrl.write_zero_request = 1'b0;
          ev[`SW_EV_WZ] = 1'b1;
        end
      swire_pkg::ST_WOR_LOW:
        if (r.tick && r.us_cnt == `SW_START_LOW_US - 10'd1)
        begin
          next_r.state = swire_pkg::ST_WOR_WAIT;
          next_r.wire_low = 1'b0;
        end
      swire_pkg::ST_WOR_WAIT:
      begin
        // a read-zero slave keeps the wire low past the sample point
        if (r.tick && r.us_cnt == `SW_READ_SAMPLE_US)
          next_r.read_bit_value = wire_in;
        if (r.tick && r.us_cnt == `SW_SLOT_US - 10'd1)
        begin
          next_r.state = swire_pkg::ST_IDLE;
          next_r.ctrl.write_one_or_read_request = 1'b0;
          ev[`SW_EV_WOR] = 1'b1;
        end
      end
      default:
      begin
        next_r.state = swire_pkg::ST_IDLE;
        next_r.wire_low = 1'b0;
      end
    endcase
    // set wins over write-one clear
    next_r.irq_stat = (r.irq_stat & ~clr) | ev;
    next_r.irq = |(next_r.irq_stat & r.irq_mask);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      r <= '0;
      r.bus.awready <= 1'b1;
      r.bus.wready <= 1'b1;
      r.bus.arready <= 1'b1;
      r.sync <= 3'h7;
      r.irq_mask <= `SW_MASK_RST;
      r.state <= swire_pkg::ST_IDLE;
    end
    else
      r <= next_r;
  end

  assign O_AWREADY = r.bus.awready;
  assign O_WREADY = r.bus.wready;
  assign O_BRESP = r.bus.bresp;
  assign O_BVALID = r.bus.bvalid;
  assign O_ARREADY = r.bus.arready;
  assign O_RDATA = r.bus.rdata;
  assign O_RRESP = r.bus.rresp;
  assign O_RVALID = r.bus.rvalid;
  assign O_WIRE = 1'b0;
  assign O_WIRE_OE = r.wire_low;
  assign O_IRQ = r.irq;
endmodule : swire_master
`default_nettype wire

// >>> pkg/swire_pkg.sv
package swire_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RST_LOW,
    ST_RST_REC,
    ST_WZ_LOW,
    ST_SLOT_REST,
    ST_WOR_LOW,
    ST_WOR_WAIT
  } seq_state_t;

  typedef struct packed {
    logic reset_presence_request;
    logic write_zero_request;
    logic write_one_or_read_request;
  } ctrl_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_t;

  typedef struct packed {
    bus_t bus;
    ctrl_t ctrl;
    logic presence_status;
    logic read_bit_value;
    logic presence_seen;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    seq_state_t state;
    logic [8:0] tb_cnt;
    logic tick;
    logic [9:0] us_cnt;
    logic wire_low;
    logic [2:0] sync;
  } state_t;
endpackage : swire_pkg

// >>> pkg/swire_regs.svh
`ifndef SWIRE_REGS_SVH
`define SWIRE_REGS_SVH
// register byte offsets
`define SW_CTRL_OFS 4'h0
`define SW_STAT_OFS 4'h4
`define SW_IRQ_OFS 4'h8
`define SW_MASK_OFS 4'hc
`define SW_DIV_OFS 4'h0
// control bit positions
`define SW_RPP_BIT 0
`define SW_WZ_BIT 1
`define SW_WOR_BIT 2
// status bit positions
`define SW_PRES_BIT 0
`define SW_RDV_BIT 1
`define SW_BUSY_BIT 2
// event bit positions
`define SW_EV_RST 0
`define SW_EV_WZ 1
`define SW_EV_WOR 2
// main clock rate and timebase divider: 250 MHz / 250 = 1 MHz exactly
`define SW_CLK_MHZ 250
`define SW_TB_DIV 9'd250
// times in microseconds, then the interrupt mask reset value
`define SW_RST_LOW_US 10'd511
`define SW_RST_REC_US 10'd512
`define SW_PRES_SAMPLE_US 10'd68
`define SW_WZ_LOW_US 10'd100
`define SW_SLOT_US 10'd117
`define SW_START_LOW_US 10'd5
`define SW_READ_SAMPLE_US 10'd13
`define SW_MASK_RST 3'h0
`endif

// >>> sim/swire_master_props.sv
`timescale 1ns/1ns
`default_nettype none
module swire_master_props (
  input wire logic I_CLK, // clock
  input wire logic I_RST_N, // reset
  input wire logic I_AWVALID, // aw valid
  input wire logic O_AWREADY, // aw ready
  input wire logic I_WVALID, // w valid
  input wire logic O_WREADY, // w ready
  input wire logic O_BVALID, // b valid
  input wire logic I_BREADY, // b ready
  input wire logic I_ARVALID, // ar valid
  input wire logic O_ARREADY, // ar ready
  input wire logic O_RVALID, // r valid
  input wire logic I_RREADY, // r ready
  input wire logic [31:0] O_RDATA, // r data
  input wire logic O_WIRE, // drive value
  input wire logic O_WIRE_OE, // pulling low
  input wire logic O_IRQ // interrupt
);
  logic [17:0] lo;
  logic [17:0] hi;
  // lo: length of the current low drive, hi: time since release
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      lo <= 18'h0;
      hi <= 18'h3ffff;
    end
    else
    begin
      lo <= O_WIRE_OE ? lo + 18'h1 : 18'h0;
      hi <= O_WIRE_OE ? 18'h0 : hi + {17'h0, ~&hi};
    end
  end
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  a_wire_only_low: assert property (O_WIRE == 1'b0)
    else $error("wire drive value not low");
  a_low_length: assert property ($fell(O_WIRE_OE) |->
    (lo >= 18'd1000 && lo <= 18'd1500) ||
    (lo >= 18'd24750 && lo <= 18'd25250) ||
    (lo >= 18'd127500 && lo <= 18'd128000))
    else $error("wire low time off");
  a_reset_min: assert property ($fell(O_WIRE_OE) && lo > 18'd30000
    |-> lo >= 18'd120000)
    else $error("reset pulse too short");
  a_release_gap: assert property ($rose(O_WIRE_OE) |-> hi >= 18'd4000)
    else $error("slot recovery too short");
  a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID &&
    O_WREADY |=> O_BVALID)
    else $error("write response late");
  a_bvalid_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
    else $error("write response dropped");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read data late");
  a_rdata_hold: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  c_reset: cover property ($fell(O_WIRE_OE) && lo > 18'd120000);
  c_irq: cover property ($rose(O_IRQ));
  c_read: cover property (O_RVALID && I_RREADY);
endmodule : swire_master_props
bind swire_master swire_master_props i_props (.*);
`default_nettype wire

// >>> sim/swire_slave.sv
`timescale 1ns/1ns
`default_nettype none
module swire_slave (
  input wire logic i_line, // wire level
  input wire logic i_present, // answer resets
  input wire logic i_zero, // answer slots with zero
  output logic o_pull // pulling low
);
  time t_fall = 0;
  initial o_pull = 1'b0;
  always @(negedge i_line)
  begin
    t_fall = $time;
    if (i_zero && !o_pull)
    begin
      o_pull = 1'b1;
      #30000 o_pull = 1'b0;
    end
  end
  always @(posedge i_line)
    if (i_present && $time - t_fall >= 480000)
    begin
      #30000 o_pull = 1'b1;
      #120000 o_pull = 1'b0;
    end
endmodule : swire_slave
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [3:0] I_AWADDR = 4'h0;
  logic I_AWVALID = 1'b0;
  logic O_AWREADY;
  logic [31:0] I_WDATA = 32'h0;
  logic [3:0] I_WSTRB = 4'hf;
  logic I_WVALID = 1'b0;
  logic O_WREADY;
  logic [1:0] O_BRESP;
  logic O_BVALID;
  logic I_BREADY = 1'b0;
  logic [3:0] I_ARADDR = 4'h0;
  logic I_ARVALID = 1'b0;
  logic O_ARREADY;
  logic [31:0] O_RDATA;
  logic [1:0] O_RRESP;
  logic O_RVALID;
  logic I_RREADY = 1'b0;
  logic I_WIRE;
  logic O_WIRE;
  logic O_WIRE_OE;
  logic O_IRQ;
  logic pull;
  logic present = 1'b1;
  logic zero = 1'b0;
  logic [31:0] v;
  logic [1:0] resp;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #2 I_CLK = ~I_CLK;
  assign I_WIRE = !(O_WIRE_OE || pull);
  swire_master i_dut (.*);
  swire_slave i_slave (.i_line(I_WIRE), .i_present(present),
    .i_zero(zero), .o_pull(pull));
  // handshakes are seen at the falling edge, acted on at the next rise
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tr;
    begin
      @(posedge I_CLK);
      I_AWADDR <= a;
      I_WDATA <= d;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_BREADY <= 1'b1;
      do
      begin
        @(negedge I_CLK);
        ta = I_AWVALID && O_AWREADY;
        tw = I_WVALID && O_WREADY;
        tr = O_BVALID;
        resp = O_BRESP;
        @(posedge I_CLK);
        if (ta) I_AWVALID <= 1'b0;
        if (tw) I_WVALID <= 1'b0;
        if (tr) I_BREADY <= 1'b0;
      end while (!tr);
    end
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ta, tr;
    begin
      @(posedge I_CLK);
      I_ARADDR <= a;
      I_ARVALID <= 1'b1;
      I_RREADY <= 1'b1;
      do
      begin
        @(negedge I_CLK);
        ta = I_ARVALID && O_ARREADY;
        tr = O_RVALID;
        d = O_RDATA;
        resp = O_RRESP;
        @(posedge I_CLK);
        if (ta) I_ARVALID <= 1'b0;
        if (tr) I_RREADY <= 1'b0;
      end while (!tr);
    end
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] e, g);
    begin
      compares++;
      if (g !== e)
      begin
        error_cnt++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask : chk
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    begin
      rd(a, v);
      chk($sformatf("reg %h", a), e, v);
      chk("rresp", 32'h0, {30'h0, resp});
    end
  endtask : rchk
  task automatic wait_done;
    int n;
    begin
      n = 0;
      do
      begin
        rd(4'h4, v);
        n++;
      end while (v[2] === 1'b1 && n < 100000);
      if (n >= 100000)
      begin
        error_cnt++;
        complete_run();
      end
    end
  endtask : wait_done
  task automatic irq_chk(input logic e);
    begin
      repeat (3) @(negedge I_CLK);
      chk("irq", {31'h0, e}, {31'h0, O_IRQ});
    end
  endtask : irq_chk
  task complete_run;
    begin
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask : complete_run
  always @(posedge I_CLK)
  begin
    cyc++;
    if (cyc == 500000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    repeat (16) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    rchk(4'h0, 32'h0);
    rchk(4'hc, 32'h0);
    wr(4'h4, 32'h7);
    chk("bresp", 32'h0, {30'h0, resp});
    rchk(4'h4, 32'h0);
    $display("register test done");
    wr(4'hc, 32'h7);
    wr(4'h0, 32'h1);
    wait_done();
    rchk(4'h4, 32'h1);
    rchk(4'h0, 32'h0);
    rchk(4'h8, 32'h1);
    irq_chk(1'b1);
    wr(4'h8, 32'h1);
    irq_chk(1'b0);
    $display("reset test done");
    wr(4'h0, 32'h2);
    wr(4'h0, 32'h4);
    wait_done();
    rchk(4'h8, 32'h2);
    rchk(4'h0, 32'h0);
    wr(4'h8, 32'h7);
    $display("write zero test done");
    wr(4'h0, 32'h4);
    wait_done();
    rchk(4'h4, 32'h3);
    wr(4'h8, 32'h4);
    $display("read one test done");
    zero <= 1'b1;
    wr(4'hc, 32'h3);
    wr(4'h0, 32'h4);
    wait_done();
    rchk(4'h4, 32'h1);
    rchk(4'h8, 32'h4);
    irq_chk(1'b0);
    wr(4'hc, 32'h7);
    irq_chk(1'b1);
    wr(4'h8, 32'h4);
    irq_chk(1'b0);
    $display("read zero test done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
